// ### pwmlk_pkg.sv
/*
 * Shared constants for the PWM fault/current-limit register block with its write lock:
 * register offsets, field positions, reset values, unlock keys and sequencer states.
 * Assumes a 32-bit AHB-Lite register bus with one aligned word per register.
 */
package pwmlk_pkg;

    // ------------------------------------------------------------------
    // Widths and register map
    // ------------------------------------------------------------------
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W = 16;
    localparam int unsigned OFS_W = 12;
    localparam logic [11:0] OFS_KEY = 12'h000;
    localparam logic [11:0] OFS_IOCON = 12'h004;
    localparam logic [11:0] OFS_FCLC = 12'h008;
    localparam logic [11:0] OFS_STAT = 12'h00c;

    // ------------------------------------------------------------------
    // Unlock keys
    // ------------------------------------------------------------------
    localparam logic [15:0] KEY_FIRST = 16'habcd;
    localparam logic [15:0] KEY_SECOND = 16'h4321;

    // ------------------------------------------------------------------
    // Fault/current-limit control fields, and reset values and write masks of both registers
    // ------------------------------------------------------------------
    localparam int unsigned LIMIT_SOURCE_SELECT_LSB = 10;
    localparam int unsigned LIMIT_SOURCE_SELECT_W = 5;
    localparam int unsigned LIMIT_POLARITY_BIT = 9;
    localparam int unsigned LIMIT_MODE_ENABLE_BIT = 8;
    localparam int unsigned FAULT_SOURCE_SELECT_LSB = 3;
    localparam int unsigned FAULT_SOURCE_SELECT_W = 5;
    localparam int unsigned FAULT_POLARITY_BIT = 2;
    localparam int unsigned FAULT_MODE_SELECT_LSB = 0;
    localparam int unsigned FAULT_MODE_SELECT_W = 2;
    localparam logic [15:0] FCLC_RESET = 16'h00f8;
    localparam logic [15:0] FCLC_WMASK = 16'h7fff;
    localparam logic [15:0] IOCON_RESET = 16'h0000;
    localparam logic [15:0] IOCON_WMASK = 16'hffff;

    // Current-limit source codes
    localparam logic [4:0] CL_FAULT_LO = 5'h00;
    localparam logic [4:0] CL_FAULT_HI = 5'h03;
    localparam logic [4:0] CL_CMP_LO = 5'h08;
    localparam logic [4:0] CL_CMP_HI = 5'h0b;
    localparam logic [4:0] CL_FAULT32 = 5'h1f;

    // ------------------------------------------------------------------
    // Status bits
    // ------------------------------------------------------------------
    localparam int unsigned STAT_LOCK_BIT = 0;
    localparam int unsigned STAT_KEY1_BIT = 1;
    localparam int unsigned STAT_ARMED_BIT = 2;

    // ------------------------------------------------------------------
    // Unlock sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PWMLK_IDLE = 2'b00,
        PWMLK_KEY1 = 2'b01,
        PWMLK_ARMED = 2'b11
    } pwmlk_state_e;

    // True when the current-limit source code is not reserved
    function automatic logic pwmlk_cl_src_valid(input logic [4:0] s);
        pwmlk_cl_src_valid = (s <= CL_FAULT_HI) || ((s >= CL_CMP_LO) && (s <= CL_CMP_HI)) ||
                             (s == CL_FAULT32);
    endfunction

endpackage

// ### pwmlk_if.sv
/*
 * Link between the register slave and the unlock sequencer.
 * Assumes both ends run on the bus clock; access is a one-cycle pulse per bus transfer.
 */
`timescale 1ns/1ps
interface pwmlk_if;
    logic access;
    logic key_wr;
    logic [15:0] key_data;
    logic prot_wr;
    logic grant;
    logic key1_seen;
    logic armed;

    modport bus (output access, output key_wr, output key_data, output prot_wr,
                 input grant, input key1_seen, input armed);
    modport seq (input access, input key_wr, input key_data, input prot_wr,
                 output grant, output key1_seen, output armed);
endinterface

// ### pwmlk_unlock.sv
/*
 * Two-key unlock sequencer for the protected registers.
 * Assumes one access pulse per completed register transfer, from the bus clock domain.
 */
`timescale 1ns/1ps
module pwmlk_unlock
    import pwmlk_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Link to the register slave
    pwmlk_if.seq lk
);

    pwmlk_state_e state_reg;
    pwmlk_state_e state_next;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        if (lk.access) begin
            unique case (state_reg)
                PWMLK_IDLE: begin
                    state_next = (lk.key_wr && lk.key_data == KEY_FIRST) ? PWMLK_KEY1 : PWMLK_IDLE;
                end
                PWMLK_KEY1: begin
                    // Wrong key or any other access drops the sequence
                    state_next = (lk.key_wr && lk.key_data == KEY_SECOND) ? PWMLK_ARMED : PWMLK_IDLE;
                end
                PWMLK_ARMED: begin
                    state_next = PWMLK_IDLE;
                end
                default: begin
                    state_next = PWMLK_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= PWMLK_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign lk.grant = (state_reg == PWMLK_ARMED) && lk.access && lk.prot_wr;
    assign lk.key1_seen = (state_reg == PWMLK_KEY1);
    assign lk.armed = (state_reg == PWMLK_ARMED);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Second key must still find the first key pending, so no access came between them
    sequence s_key_pair;
        lk.access && lk.key_wr && lk.key_data == KEY_FIRST && state_reg == PWMLK_IDLE
        ##[2:9] lk.access && lk.key_wr && lk.key_data == KEY_SECOND && lk.key1_seen;
    endsequence

    property p_key_pair_arms;
        @(posedge hclk) disable iff (!hresetn)
        s_key_pair |=> lk.armed;
    endproperty
    a_key_pair_arms: assert property (p_key_pair_arms) else $error("key pair did not arm");

    property p_stray_access_drops;
        @(posedge hclk) disable iff (!hresetn)
        lk.armed && lk.access && !lk.prot_wr |=> !lk.armed && !lk.key1_seen;
    endproperty
    a_stray_access_drops: assert property (p_stray_access_drops) else $error("unlock kept");

    property p_one_write_per_unlock;
        @(posedge hclk) disable iff (!hresetn)
        lk.grant |=> !lk.armed ##1 !lk.grant;
    endproperty
    a_one_write_per_unlock: assert property (p_one_write_per_unlock) else $error("reuse");

    property p_bad_key_abandons;
        @(posedge hclk) disable iff (!hresetn)
        lk.key1_seen && lk.access && !(lk.key_wr && lk.key_data == KEY_SECOND) |=>
            !lk.armed && !lk.key1_seen;
    endproperty
    a_bad_key_abandons: assert property (p_bad_key_abandons) else $error("bad key kept");

endmodule

// ### pwmlk_top.sv
/*
 * AHB-Lite register slave for the PWM output-control and fault/current-limit control
 * registers, with the two-key write lock governed by the lock configuration bit.
 * Assumes a single AHB-Lite master, word transfers, and a lock configuration level
 * arriving asynchronously from the configuration store.
 */
`timescale 1ns/1ps
module pwmlk_top
    import pwmlk_pkg::*;
#(
    parameter int unsigned ADDR_W = 32
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic [DATA_W-1:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Lock configuration level
    input wire logic protect_lock_config_bit,
    // Register contents to the PWM generator
    output logic [REG_W-1:0] pwm_output_control,
    output logic [4:0] limit_source_select,
    output logic limit_polarity,
    output logic limit_mode_enable,
    output logic limit_source_reserved,
    output logic [4:0] fault_source_select,
    output logic fault_polarity,
    output logic [1:0] fault_mode_select
);

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    if (ADDR_W < OFS_W || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W must lie between OFS_W and 32");
    end

    logic lock_meta_reg;
    logic lock_sync_reg;
    logic ap_valid_reg;
    logic ap_write_reg;
    logic [OFS_W-1:0] ap_addr_reg;
    logic hreadyout_reg;
    logic hresp_reg;
    logic [DATA_W-1:0] hrdata_reg;
    logic [REG_W-1:0] iocon_reg;
    logic [REG_W-1:0] fclc_reg;
    logic reserved_reg;
    logic take;
    logic sel_key;
    logic sel_iocon;
    logic sel_fclc;
    logic sel_stat;
    logic wr_open;
    logic iocon_we;
    logic fclc_we;
    logic [REG_W-1:0] rd_mux;

    pwmlk_if lk ();

    pwmlk_unlock pwmlk_unlock_inst (
        .hclk(hclk),
        .hresetn(hresetn),
        .lk(lk)
    );

    // ------------------------------------------------------------------
    // Lock configuration synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_meta_reg <= 1'b1;
            lock_sync_reg <= 1'b1;
        end else begin
            lock_meta_reg <= protect_lock_config_bit;
            lock_sync_reg <= lock_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // Bus address phase and wait state
    // ------------------------------------------------------------------
    assign take = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid_reg <= 1'b0;
            ap_write_reg <= 1'b0;
            ap_addr_reg <= '0;
        end else if (take) begin
            ap_valid_reg <= 1'b1;
            ap_write_reg <= hwrite;
            ap_addr_reg <= haddr[OFS_W-1:0];
        end else begin
            ap_valid_reg <= 1'b0;
        end
    end

    // One wait state per transfer so reads see writes completed just before
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_reg <= 1'b1;
            hresp_reg <= 1'b0;
        end else begin
            hresp_reg <= 1'b0;
            if (take) begin
                hreadyout_reg <= 1'b0;
            end else if (ap_valid_reg) begin
                hreadyout_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Decode and lock gating
    // ------------------------------------------------------------------
    assign sel_key = (ap_addr_reg == OFS_KEY);
    assign sel_iocon = (ap_addr_reg == OFS_IOCON);
    assign sel_fclc = (ap_addr_reg == OFS_FCLC);
    assign sel_stat = (ap_addr_reg == OFS_STAT);

    // Every transfer, mapped or not, counts as an access to the sequencer
    assign lk.access = ap_valid_reg;
    assign lk.key_wr = ap_write_reg && sel_key;
    assign lk.key_data = hwdata[15:0];
    assign lk.prot_wr = ap_write_reg && (sel_iocon || sel_fclc);

    assign wr_open = !lock_sync_reg || lk.grant;
    assign iocon_we = ap_valid_reg && ap_write_reg && sel_iocon && wr_open;
    assign fclc_we = ap_valid_reg && ap_write_reg && sel_fclc && wr_open;

    // ------------------------------------------------------------------
    // Protected registers
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            iocon_reg <= IOCON_RESET;
        end else if (iocon_we) begin
            iocon_reg <= hwdata[15:0] & IOCON_WMASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fclc_reg <= FCLC_RESET;
            reserved_reg <= 1'b0;
        end else if (fclc_we) begin
            fclc_reg <= hwdata[15:0] & FCLC_WMASK;
            reserved_reg <= !pwmlk_cl_src_valid(hwdata[LIMIT_SOURCE_SELECT_LSB +: LIMIT_SOURCE_SELECT_W]);
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_comb begin
        rd_mux = '0;
        if (sel_iocon) begin
            rd_mux = iocon_reg;
        end else if (sel_fclc) begin
            rd_mux = fclc_reg;
        end else if (sel_stat) begin
            rd_mux[STAT_LOCK_BIT] = lock_sync_reg;
            rd_mux[STAT_KEY1_BIT] = lk.key1_seen;
            rd_mux[STAT_ARMED_BIT] = lk.armed;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= '0;
        end else if (ap_valid_reg && !ap_write_reg) begin
            hrdata_reg <= {16'h0000, rd_mux};
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign hrdata = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp = hresp_reg;
    assign pwm_output_control = iocon_reg;
    assign limit_source_select = fclc_reg[LIMIT_SOURCE_SELECT_LSB +: LIMIT_SOURCE_SELECT_W];
    assign limit_polarity = fclc_reg[LIMIT_POLARITY_BIT];
    assign limit_mode_enable = fclc_reg[LIMIT_MODE_ENABLE_BIT];
    assign limit_source_reserved = reserved_reg;
    assign fault_source_select = fclc_reg[FAULT_SOURCE_SELECT_LSB +: FAULT_SOURCE_SELECT_W];
    assign fault_polarity = fclc_reg[FAULT_POLARITY_BIT];
    assign fault_mode_select = fclc_reg[FAULT_MODE_SELECT_LSB +: FAULT_MODE_SELECT_W];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_fclc_write_dp;
        ap_valid_reg && ap_write_reg && sel_fclc;
    endsequence

    property p_locked_write_ignored;
        @(posedge hclk) disable iff (!hresetn)
        s_fclc_write_dp and (lock_sync_reg && !lk.armed) |=> $stable(fclc_reg);
    endproperty
    a_locked_write_ignored: assert property (p_locked_write_ignored) else $error("lock bypassed");

    property p_open_write_lands;
        @(posedge hclk) disable iff (!hresetn)
        s_fclc_write_dp and !lock_sync_reg |=> fclc_reg == ($past(hwdata[15:0]) & FCLC_WMASK);
    endproperty
    a_open_write_lands: assert property (p_open_write_lands) else $error("open write lost");

    property p_reserved_flag;
        @(posedge hclk) disable iff (!hresetn)
        limit_source_reserved == !pwmlk_cl_src_valid(limit_source_select);
    endproperty
    a_reserved_flag: assert property (p_reserved_flag) else $error("reserved flag wrong");

    property p_polarity_follows;
        @(posedge hclk) disable iff (!hresetn)
        fclc_we |=> limit_polarity == $past(hwdata[LIMIT_POLARITY_BIT]);
    endproperty
    a_polarity_follows: assert property (p_polarity_follows) else $error("polarity wrong");

    property p_mode_follows;
        @(posedge hclk) disable iff (!hresetn)
        fclc_we |=> limit_mode_enable == $past(hwdata[LIMIT_MODE_ENABLE_BIT]) ##1 $stable(limit_mode_enable)
            or fclc_we;
    endproperty
    a_mode_follows: assert property (p_mode_follows) else $error("mode bit wrong");

    property p_bit15_reads_zero;
        @(posedge hclk) disable iff (!hresetn)
        ap_valid_reg && !ap_write_reg && sel_fclc |=> hreadyout && hrdata[31:15] == 17'h00000;
    endproperty
    a_bit15_reads_zero: assert property (p_bit15_reads_zero) else $error("bit 15 set");

    property p_fault_fields;
        @(posedge hclk) disable iff (!hresetn)
        fclc_we |=> {fault_source_select, fault_polarity, fault_mode_select} == $past(hwdata[7:0]);
    endproperty
    a_fault_fields: assert property (p_fault_fields) else $error("fault fields wrong");

endmodule

// ### tb.sv
/*
 * Self-checking bench for the locked PWM fault/current-limit register block.
 * Assumes pwmlk_pkg and pwmlk_top as delivered, a single AHB-Lite master and hready looped
 * back from hreadyout.
 */
`timescale 1ns/1ps
module tb
    import pwmlk_pkg::*;
;
    typedef struct packed {
        logic unl;
        logic [11:0] a;
        logic [15:0] wd;
        logic [15:0] exp;
    } pwmlk_row_s;

    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic protect_lock_config_bit;
    logic [15:0] pwm_output_control;
    logic [4:0] limit_source_select;
    logic limit_polarity;
    logic limit_mode_enable;
    logic limit_source_reserved;
    logic [4:0] fault_source_select;
    logic fault_polarity;
    logic [1:0] fault_mode_select;
    int n_errors;
    int cmp_count;
    logic [31:0] rv;
    pwmlk_row_s rows[13];

    pwmlk_top #(.ADDR_W(32)) pwmlk_top_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .protect_lock_config_bit(protect_lock_config_bit),
        .pwm_output_control(pwm_output_control), .limit_source_select(limit_source_select),
        .limit_polarity(limit_polarity), .limit_mode_enable(limit_mode_enable),
        .limit_source_reserved(limit_source_reserved),
        .fault_source_select(fault_source_select), .fault_polarity(fault_polarity),
        .fault_mode_select(fault_mode_select)
    );

    // ------------------------------------------------------------------
    // Clock, checking and closing
    // ------------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    function automatic logic rsv(input logic [4:0] s);
        return !((s <= 5'h03) || (s >= 5'h08 && s <= 5'h0b) || s == 5'h1f);
    endfunction

    // ------------------------------------------------------------------
    // Bus master: called right after a rising edge
    // ------------------------------------------------------------------
    task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d,
                        output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {20'h0, a};
        hwrite <= w;
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {16'ha5a5, d};
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
        rd = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        logic [31:0] x;
        xfer(1'b1, a, d, x);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [15:0] exp);
        logic [31:0] x;
        xfer(1'b0, a, 16'h0, x);
        check(x, {16'h0, exp});
    endtask

    task automatic unlock();
        wr(OFS_KEY, KEY_FIRST);
        wr(OFS_KEY, KEY_SECOND);
    endtask

    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask

    initial begin
        #20000;
        n_errors++;
        report_and_stop();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        n_errors = 0;
        cmp_count = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        protect_lock_config_bit = 1'b1;
        rows = '{
            '{1'b0, OFS_FCLC, 16'h1234, 16'h00f8}, '{1'b0, OFS_IOCON, 16'h5555, 16'h0000},
            '{1'b1, OFS_FCLC, 16'hffff, 16'h7fff}, '{1'b1, OFS_IOCON, 16'hf000, 16'hf000},
            '{1'b1, OFS_FCLC, 16'h0f07, 16'h0f07}, '{1'b1, OFS_FCLC, 16'h21ab, 16'h21ab},
            '{1'b1, OFS_FCLC, 16'h2e54, 16'h2e54}, '{1'b1, OFS_FCLC, 16'h7f00, 16'h7f00},
            '{1'b1, OFS_FCLC, 16'h1000, 16'h1000}, '{1'b1, OFS_FCLC, 16'h3000, 16'h3000},
            '{1'b1, OFS_FCLC, 16'hf8f8, 16'h78f8}, '{1'b1, OFS_FCLC, 16'h1c00, 16'h1c00},
            '{1'b1, OFS_FCLC, 16'h0000, 16'h0000}};
        do_reset();
        rd_chk(OFS_FCLC, FCLC_RESET);
        rd_chk(OFS_IOCON, 16'h0000);
        rd_chk(OFS_STAT, 16'h0001);
        rd_chk(OFS_KEY, 16'h0000);
        foreach (rows[i]) begin
            if (rows[i].unl) begin
                unlock();
            end
            wr(rows[i].a, rows[i].wd);
            rd_chk(rows[i].a, rows[i].exp);
            if (rows[i].a == OFS_FCLC) begin
                check({16'h0, 1'b0, limit_source_select, limit_polarity, limit_mode_enable,
                       fault_source_select, fault_polarity, fault_mode_select},
                      {16'h0, rows[i].exp});
                check({31'h0, limit_source_reserved}, {31'h0, rsv(rows[i].exp[14:10])});
            end
        end
        check({16'h0, pwm_output_control}, 32'h0000f000);
        // One unlock, one write
        unlock();
        wr(OFS_FCLC, 16'h0100);
        wr(OFS_FCLC, 16'h0200);
        rd_chk(OFS_FCLC, 16'h0100);
        wr(OFS_IOCON, 16'h1111);
        rd_chk(OFS_IOCON, 16'hf000);
        // Stray accesses inside the sequence
        unlock();
        xfer(1'b0, OFS_STAT, 16'h0, rv);
        check(rv, 32'h00000005);
        wr(OFS_FCLC, 16'h0300);
        rd_chk(OFS_FCLC, 16'h0100);
        wr(OFS_KEY, KEY_FIRST);
        rd_chk(12'h100, 16'h0000);
        wr(OFS_KEY, KEY_SECOND);
        wr(OFS_FCLC, 16'h0300);
        rd_chk(OFS_FCLC, 16'h0100);
        // Wrong keys
        wr(OFS_KEY, 16'h1234);
        wr(OFS_KEY, KEY_SECOND);
        wr(OFS_FCLC, 16'h0300);
        rd_chk(OFS_FCLC, 16'h0100);
        wr(OFS_KEY, KEY_FIRST);
        wr(OFS_KEY, KEY_FIRST);
        wr(OFS_KEY, KEY_SECOND);
        wr(OFS_FCLC, 16'h0300);
        rd_chk(OFS_FCLC, 16'h0100);
        wr(OFS_KEY, KEY_FIRST);
        wr(OFS_KEY, 16'h4320);
        wr(OFS_IOCON, 16'h0abc);
        rd_chk(OFS_IOCON, 16'hf000);
        unlock();
        wr(OFS_IOCON, 16'h0abc);
        rd_chk(OFS_IOCON, 16'h0abc);
        // Read-only and unmapped places
        wr(OFS_STAT, 16'hffff);
        rd_chk(OFS_STAT, 16'h0001);
        wr(12'h010, 16'hffff);
        rd_chk(12'h010, 16'h0000);
        // Lock disabled by the configuration bit
        protect_lock_config_bit <= 1'b0;
        repeat (4) @(posedge hclk);
        rd_chk(OFS_STAT, 16'h0000);
        wr(OFS_FCLC, 16'h7c00);
        rd_chk(OFS_FCLC, 16'h7c00);
        wr(OFS_IOCON, 16'h00ff);
        rd_chk(OFS_IOCON, 16'h00ff);
        protect_lock_config_bit <= 1'b1;
        repeat (4) @(posedge hclk);
        wr(OFS_FCLC, 16'h0000);
        rd_chk(OFS_FCLC, 16'h7c00);
        // Reset in mid-run
        do_reset();
        check({16'h0, pwm_output_control}, 32'h0);
        check(hrdata, 32'h0);
        check({31'h0, hreadyout}, 32'h1);
        check({27'h0, fault_source_select}, 32'h1f);
        rd_chk(OFS_FCLC, FCLC_RESET);
        wr(OFS_FCLC, 16'h0000);
        rd_chk(OFS_FCLC, FCLC_RESET);
        report_and_stop();
    end
endmodule
